// ==== hdl/hps_pkg.sv ====
// Shared constants for the host port status flag bank and its controller
package hps_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CREDIT_W = 5;
  localparam int FLAG_W = 13;

  // Device register map
  localparam logic [7:0] STATUS_ZERO_OFFSET = 8'h08;
  localparam logic [31:0] STATUS_ZERO_RESET = 32'h00000040;

  // Field positions inside the status register
  localparam int CTRL_PROTECT_ERR_BIT = 12;
  localparam int TX_CHECK_SEQ_ERR_BIT = 11;
  localparam int TX_STAMP_READY_C_BIT = 10;
  localparam int TX_STAMP_READY_B_BIT = 9;
  localparam int TX_STAMP_READY_A_BIT = 8;
  localparam int PORT1_PHY_IRQ_BIT = 7;
  localparam int RESET_DONE_FLAG_BIT = 6;
  localparam int HEADER_PARITY_ERR_BIT = 5;
  localparam int CS_EARLY_LOSS_ERR_BIT = 4;
  localparam int RX_OVERFLOW_ERR_BIT = 3;
  localparam int TX_UNDERRUN_ERR_BIT = 2;
  localparam int TX_OVERFLOW_ERR_BIT = 1;
  localparam int TX_PROTO_ERR_BIT = 0;

  // Bits that a write of one clears; bit 7 and the reserved bits are read-only
  localparam logic [12:0] W1C_MASK = 13'h1F7F;

  // Transmit FIFO sizing and credit granularity
  localparam int TX_FIFO_BYTES = 4096;
  localparam int CHUNK_BYTES = 64;
  localparam logic [4:0] CREDIT_MAX = 5'h1F;

  // Controller register map on its software port
  localparam logic [7:0] HOST_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] HOST_COPY_OFFSET = 8'h04;
  localparam logic [7:0] HOST_CLEAR_OFFSET = 8'h08;
  localparam logic [7:0] HOST_LINK_OFFSET = 8'h0C;
  localparam int HOST_AUTO_CLR_BIT = 0;
  localparam int HOST_POLL_BIT = 1;
  localparam logic HOST_AUTO_CLR_RESET = 1'b1;
  // Extra cycles after a clear so the retimed pin shows it before a new poll
  localparam logic [1:0] HOST_SETTLE = 2'h2;
endpackage : hps_pkg

// ==== hdl/hps_link_if.sv ====
// Register and interrupt link between the status bank and its host controller
`timescale 1ns/10ps
interface hps_link_if;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic int_n;
  logic footer_ext_status_bit;
  logic [4:0] footer_tx_credit;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output int_n,
    output footer_ext_status_bit,
    output footer_tx_credit
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input int_n,
    input footer_ext_status_bit,
    input footer_tx_credit
  );
endinterface : hps_link_if

// ==== hdl/hps_sync.sv ====
// Two-stage synchroniser for a level arriving from outside the clock domain
`timescale 1ns/10ps
module hps_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } hps_sync_state_t;

  hps_sync_state_t state_reg;
  hps_sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.meta = din;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '{meta: RESET_VAL, stable: RESET_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.stable;
endmodule : hps_sync

// ==== hdl/hps_status_dev.sv ====
// Device end: status and error flag bank of the host port
//
// Summary of operation
// RL1: Status resets to 0x40, bit 7 reads set until first read, upper bits read zero
// RL2: Reset-done flag holds interrupt pin low
// RL3: Reset-done flag raises footer extended-status bit
// RL4: Sticky flags clear only by writing one
// RL5: Protection error sets bit 12 when implemented
// RL6: Early chip-select loss sets bit 4
// RL7: Protection error also sets loss-of-frame
// RL8: Bad host frame check sets bit 11
// RL9: Bits 10..8 flag stamp slots C,B,A
// RL10: Bit 7 mirrors port 1 PHY interrupt
// RL11: PHY flag up after reset, masked by default
// RL12: Header parity failure sets bit 5 in chunk mode
// RL13: Receive buffer overflow sets bit 3
// RL14: Underrun flag only with cut-through; stops packet
// RL15: Host outpaces line rate in cut-through
// RL16: Overflow sets bit 1, drops frame until SOF
// RL17: Host checks free space before writing
// RL18: Transmit FIFO holds at least 4 kB
// RL19: Chunk DV without SV or repeated SV errors
// RL20: Size write during unfinished frame errors outside chunk mode
// RL21: Zero writes keep flags; set beats clear
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module hps_status_dev #(
  parameter bit PROTECT_IMPL = 1'b1,
  parameter int TX_FIFO_BYTES = hps_pkg::TX_FIFO_BYTES
) (
  input wire logic clk,
  input wire logic resetn,
  hps_link_if.dev link,
  input wire logic reset_done_evt,
  input wire logic ctrl_protect_evt,
  input wire logic cs_early_loss_evt,
  input wire logic header_parity_evt,
  input wire logic tx_check_seq_evt,
  input wire logic [2:0] tx_stamp_evt,
  input wire logic port1_phy_irq_in,
  input wire logic phy_irq_unmask,
  input wire logic rx_overflow_evt,
  input wire logic cut_through_en,
  input wire logic tx_underrun_evt,
  output logic tx_abort,
  input wire logic tx_overflow_evt,
  input wire logic tx_wr,
  input wire logic tx_sof,
  output logic tx_wr_accept,
  output logic tx_discard,
  input wire logic chunk_mode,
  input wire logic chunk_dv,
  input wire logic chunk_sv,
  input wire logic chunk_ev,
  input wire logic tx_frame_size_reg_wr,
  input wire logic tx_frame_incomplete,
  input wire logic [15:0] tx_fifo_used
);
  // A FIFO below 4 kB could let an overflow cut a frame in flight
  // RL18: FIFO size floor
  localparam bit FIFO_SIZE_OK = (TX_FIFO_BYTES >= hps_pkg::TX_FIFO_BYTES);
  localparam logic [16:0] FIFO_BYTES_W = 17'(TX_FIFO_BYTES);

  typedef struct packed {
    logic [12:0] flags;
    logic in_frame;
    logic drop;
    logic phy_boot;
    logic abort;
    logic [31:0] rdata;
    logic [4:0] credit;
  } hps_dev_state_t;

  hps_dev_state_t state_reg;
  hps_dev_state_t state_next;
  logic phy_irq_sync;
  logic [12:0] set_vec;
  logic [12:0] clr_vec;
  logic hit_wr;
  logic hit_rd;
  logic proto_chunk_err;
  logic phy_bit;

  // Free space in whole chunks, saturated to the footer field
  function automatic logic [4:0] hps_credit(input logic [15:0] used);
    logic [16:0] free_bytes;
    logic [16:0] chunks;
    free_bytes = 17'h00000;
    chunks = 17'h00000;
    if ({1'b0, used} < FIFO_BYTES_W) begin
      free_bytes = FIFO_BYTES_W - {1'b0, used};
    end
    chunks = free_bytes / 17'(hps_pkg::CHUNK_BYTES);
    if (chunks > {12'h000, hps_pkg::CREDIT_MAX}) begin
      hps_credit = hps_pkg::CREDIT_MAX;
    end else begin
      hps_credit = chunks[4:0];
    end
  endfunction : hps_credit

  // The PHY interrupt comes from another block's timing, so it is retimed
  hps_sync #(
    .RESET_VAL(1'b0)
  ) u_phy_sync (
    .clk(clk),
    .resetn(resetn),
    .din(port1_phy_irq_in),
    .dout(phy_irq_sync)
  );

  // Register decode
  assign hit_wr = link.wr && (link.addr == hps_pkg::STATUS_ZERO_OFFSET);
  assign hit_rd = link.rd && (link.addr == hps_pkg::STATUS_ZERO_OFFSET);

  // Chunk framing: data without a start, or a start inside an open frame
  // RL19: chunk framing check
  assign proto_chunk_err = chunk_mode && chunk_dv &&
                           ((!state_reg.in_frame && !chunk_sv) ||
                            (state_reg.in_frame && chunk_sv));

  // Bit 7 follows the PHY line, plus a boot latch until first read
  // RL10: PHY mirror
  // RL11: asserted after reset
  assign phy_bit = phy_irq_sync || state_reg.phy_boot;

  // Hardware set events per flag
  always_comb begin
    set_vec = 13'h0000;
    // RL2: internal reset finished
    set_vec[hps_pkg::RESET_DONE_FLAG_BIT] = reset_done_evt;
    // RL5: protection error only if built
    set_vec[hps_pkg::CTRL_PROTECT_ERR_BIT] = PROTECT_IMPL && ctrl_protect_evt;
    // RL6: early chip-select loss
    // RL7: protection error drags loss-of-frame
    set_vec[hps_pkg::CS_EARLY_LOSS_ERR_BIT] = cs_early_loss_evt ||
                                              (PROTECT_IMPL && ctrl_protect_evt);
    // RL8: bad frame check on host frame
    set_vec[hps_pkg::TX_CHECK_SEQ_ERR_BIT] = tx_check_seq_evt;
    // RL9: stamp slots C, B, A
    set_vec[hps_pkg::TX_STAMP_READY_C_BIT] = tx_stamp_evt[2];
    set_vec[hps_pkg::TX_STAMP_READY_B_BIT] = tx_stamp_evt[1];
    set_vec[hps_pkg::TX_STAMP_READY_A_BIT] = tx_stamp_evt[0];
    // RL12: header parity failure
    set_vec[hps_pkg::HEADER_PARITY_ERR_BIT] = chunk_mode && header_parity_evt;
    // RL13: receive buffer overflow
    set_vec[hps_pkg::RX_OVERFLOW_ERR_BIT] = rx_overflow_evt;
    // RL14: underrun counts only in cut-through
    set_vec[hps_pkg::TX_UNDERRUN_ERR_BIT] = cut_through_en && tx_underrun_evt;
    // RL16: host FIFO overflow
    set_vec[hps_pkg::TX_OVERFLOW_ERR_BIT] = tx_overflow_evt;
    // RL19: chunk protocol error
    // RL20: size written over unfinished frame
    set_vec[hps_pkg::TX_PROTO_ERR_BIT] = proto_chunk_err ||
                                         (!chunk_mode && tx_frame_size_reg_wr &&
                                          tx_frame_incomplete);
  end

  // Write-one clears, restricted to the clearable bits
  // RL4: write one to clear
  assign clr_vec = hit_wr ? (link.wdata[12:0] & hps_pkg::W1C_MASK) : 13'h0000;

  // Next-state logic for flags, framing and read data
  always_comb begin
    state_next = state_reg;
    // RL21: set wins over clear, zero keeps
    state_next.flags = (state_reg.flags & ~clr_vec) | set_vec;
    state_next.flags[hps_pkg::PORT1_PHY_IRQ_BIT] = 1'b0;
    if (!PROTECT_IMPL) begin
      state_next.flags[hps_pkg::CTRL_PROTECT_ERR_BIT] = 1'b0;
    end
    // Frame tracking for the chunk protocol
    if (chunk_mode && chunk_dv) begin
      if (chunk_ev) begin
        state_next.in_frame = 1'b0;
      end else if (chunk_sv) begin
        state_next.in_frame = 1'b1;
      end
    end
    // Overflow discards the frame until the next start of frame
    // RL16: drop until SOF
    if (tx_overflow_evt) begin
      state_next.drop = 1'b1;
    end else if (tx_sof) begin
      state_next.drop = 1'b0;
    end
    // RL14: stop packet on underrun
    state_next.abort = cut_through_en && tx_underrun_evt;
    // Boot indication is dropped once software has seen it
    if (hit_rd) begin
      state_next.phy_boot = 1'b0;
    end
    // RL17: credit for the footer
    state_next.credit = FIFO_SIZE_OK ? hps_credit(tx_fifo_used) : 5'h00;
    // Read data is valid only in the cycle after the strobe
    // RL1: reserved bits read zero
    state_next.rdata = 32'h00000000;
    if (hit_rd) begin
      state_next.rdata[12:0] = state_reg.flags;
      state_next.rdata[hps_pkg::PORT1_PHY_IRQ_BIT] = phy_bit;
    end
  end

  // RL1: reset value with only reset-done set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '{flags: hps_pkg::STATUS_ZERO_RESET[12:0],
                     in_frame: 1'b0,
                     drop: 1'b0,
                     phy_boot: 1'b1,
                     abort: 1'b0,
                     rdata: 32'h00000000,
                     credit: 5'h00};
    end else begin
      state_reg <= state_next;
    end
  end

  // Interrupt pin: reset-done is nonmaskable, PHY line is gated
  // RL2: nonmaskable reset-done assertion
  // RL11: PHY interrupt masked by default
  assign link.int_n = !(state_reg.flags[hps_pkg::RESET_DONE_FLAG_BIT] ||
                        (phy_bit && phy_irq_unmask));
  // RL3: extended status while reset-done set
  assign link.footer_ext_status_bit = state_reg.flags[hps_pkg::RESET_DONE_FLAG_BIT];
  assign link.footer_tx_credit = state_reg.credit;
  assign link.rdata = state_reg.rdata;

  // Writes during a discarded frame are swallowed
  // RL16: ignore writes until SOF
  assign tx_wr_accept = tx_wr && !state_reg.drop && !tx_overflow_evt;
  assign tx_discard = state_reg.drop;
  assign tx_abort = state_reg.abort;
endmodule : hps_status_dev

// ==== hdl/hps_status_host.sv ====
// Host end: reads and acknowledges the status flags over the register link
`timescale 1ns/10ps
module hps_status_host (
  input wire logic clk,
  input wire logic resetn,
  hps_link_if.host link,
  input wire logic [7:0] usr_addr,
  input wire logic [31:0] usr_wdata,
  input wire logic usr_wr,
  input wire logic usr_rd,
  output logic [31:0] usr_rdata,
  input wire logic [4:0] tx_need_chunks,
  output logic tx_may_write
);
  typedef enum logic [3:0] {
    HPS_IDLE = 4'h1,
    HPS_READ = 4'h2,
    HPS_WAIT = 4'h4,
    HPS_CLEAR = 4'h8
  } hps_host_fsm_t;

  typedef struct packed {
    hps_host_fsm_t fsm;
    logic auto_clr;
    logic poll_pend;
    logic clr_pend;
    logic [12:0] clr_mask;
    logic [31:0] copy;
    logic [31:0] usr_rdata;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [1:0] settle;
  } hps_host_state_t;

  hps_host_state_t state_reg;
  hps_host_state_t state_next;
  logic int_sync_n;

  // The interrupt pin is retimed before the state machine looks at it
  hps_sync #(
    .RESET_VAL(1'b1)
  ) u_int_sync (
    .clk(clk),
    .resetn(resetn),
    .din(link.int_n),
    .dout(int_sync_n)
  );

  // Software port, bus sequencing and acknowledge of set flags
  always_comb begin
    state_next = state_reg;
    state_next.wr = 1'b0;
    state_next.rd = 1'b0;
    state_next.usr_rdata = 32'h00000000;
    if (usr_rd) begin
      case (usr_addr)
        hps_pkg::HOST_CTRL_OFFSET: state_next.usr_rdata = {31'h00000000, state_reg.auto_clr};
        hps_pkg::HOST_COPY_OFFSET: state_next.usr_rdata = state_reg.copy;
        hps_pkg::HOST_LINK_OFFSET: state_next.usr_rdata = {23'h000000, !int_sync_n,
                                                   link.footer_ext_status_bit,
                                                   2'h0, link.footer_tx_credit};
        default: state_next.usr_rdata = 32'h00000000;
      endcase
    end
    // Sequencer: one bus access at a time, never stalled by the device
    case (state_reg.fsm)
      HPS_IDLE: begin
        if (state_reg.clr_pend) begin
          // RL4: write-one acknowledge
          // Acknowledge by writing ones only to the chosen bits
          state_next.wr = 1'b1;
          state_next.addr = hps_pkg::STATUS_ZERO_OFFSET;
          state_next.wdata = {19'h00000, state_reg.clr_mask};
          state_next.clr_pend = 1'b0;
          state_next.clr_mask = 13'h0000;
          state_next.fsm = HPS_CLEAR;
          state_next.settle = hps_pkg::HOST_SETTLE;
        end else if (state_reg.poll_pend || !int_sync_n) begin
          state_next.rd = 1'b1;
          state_next.addr = hps_pkg::STATUS_ZERO_OFFSET;
          state_next.poll_pend = 1'b0;
          state_next.fsm = HPS_READ;
        end
      end
      HPS_READ: begin
        state_next.fsm = HPS_WAIT;
      end
      HPS_WAIT: begin
        // Read data stands only in this cycle
        state_next.copy = link.rdata;
        if (state_reg.auto_clr && (link.rdata[12:0] & hps_pkg::W1C_MASK) != 13'h0000) begin
          state_next.clr_pend = 1'b1;
          state_next.clr_mask = state_next.clr_mask | (link.rdata[12:0] & hps_pkg::W1C_MASK);
        end
        state_next.fsm = HPS_IDLE;
      end
      HPS_CLEAR: begin
        // The pin passes two sync stages, so wait or a stale low re-polls
        if (state_reg.settle != 2'h0) begin
          state_next.settle = state_reg.settle - 2'h1;
        end else begin
          state_next.fsm = HPS_IDLE;
        end
      end
      default: begin
        state_next.fsm = HPS_IDLE;
      end
    endcase
    // User requests go last so a busy sequencer never drops them
    if (usr_wr && usr_addr == hps_pkg::HOST_CTRL_OFFSET) begin
      state_next.auto_clr = usr_wdata[hps_pkg::HOST_AUTO_CLR_BIT];
      if (usr_wdata[hps_pkg::HOST_POLL_BIT]) begin
        state_next.poll_pend = 1'b1;
      end
    end
    if (usr_wr && usr_addr == hps_pkg::HOST_CLEAR_OFFSET) begin
      state_next.clr_pend = 1'b1;
      state_next.clr_mask = state_next.clr_mask | (usr_wdata[12:0] & hps_pkg::W1C_MASK);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '{fsm: HPS_IDLE,
                     auto_clr: hps_pkg::HOST_AUTO_CLR_RESET,
                     poll_pend: 1'b0,
                     clr_pend: 1'b0,
                     clr_mask: 13'h0000,
                     copy: 32'h00000000,
                     usr_rdata: 32'h00000000,
                     addr: 8'h00,
                     wdata: 32'h00000000,
                     wr: 1'b0,
                     rd: 1'b0,
                     settle: 2'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.addr = state_reg.addr;
  assign link.wdata = state_reg.wdata;
  assign link.wr = state_reg.wr;
  assign link.rd = state_reg.rd;
  assign usr_rdata = state_reg.usr_rdata;
  // RL17: write only with enough credit
  assign tx_may_write = (link.footer_tx_credit >= tx_need_chunks) && (tx_need_chunks != 5'h00);
endmodule : hps_status_host

// ==== testbench/hps_monitor.sv ====
// Protocol checker for the status link between the host and device ends
`timescale 1ns/10ps
module hps_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic int_n,
  input wire logic footer_ext_status_bit,
  input wire logic [4:0] footer_tx_credit
);
  // One clock domain, so clocking and reset are declared once
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_rsvd_zero;
    rdata[31:13] == 19'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved status bits not zero");

  property p_rdata_idle;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside the answer cycle");

  property p_rd_ext;
    $past(rd) && $past(addr) == 8'h08 |-> rdata[6] == $past(footer_ext_status_bit);
  endproperty
  a_rd_ext: assert property (p_rd_ext)
    else $error("footer extended bit disagrees with reset-done flag");

  property p_int_on_done;
    footer_ext_status_bit |-> !int_n;
  endproperty
  a_int_on_done: assert property (p_int_on_done)
    else $error("interrupt not asserted while reset-done set");

  property p_done_sticky;
    footer_ext_status_bit && !(wr && addr == 8'h08 && wdata[6]) |=> footer_ext_status_bit;
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("reset-done flag dropped without a clear");

  property p_done_clear;
    wr && addr == 8'h08 && wdata[6] |=> !footer_ext_status_bit;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("reset-done flag not cleared by write of one");

  property p_strobe_excl;
    !(wr && rd);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("read and write strobes together");

  property p_poll_on_int;
    $fell(int_n) |-> ##[1:8] (rd && addr == 8'h08);
  endproperty
  a_poll_on_int: assert property (p_poll_on_int)
    else $error("host did not read status after interrupt");
endmodule : hps_monitor

// ==== testbench/test_host_port_status_flags.sv ====
// Self-checking bench joining the device and host ends of the status link
`timescale 1ns/10ps
module test_host_port_status_flags;
  logic clk, resetn, chunk_mode, cut_en, incomplete, phy_in, phy_unmask;
  logic tx_abort, tx_wr_accept, tx_discard, tx_may_write, usr_wr, usr_rd, last_abort, last_acc;
  logic [16:0] ev;
  logic [15:0] fifo_used;
  logic [4:0] need;
  logic [7:0] usr_addr;
  logic [31:0] usr_wdata, usr_rdata;
  int n_mismatch = 0;
  int compares = 0;

  hps_link_if link();
  hps_status_dev i_hps_status_dev (.clk(clk), .resetn(resetn), .link(link.dev),
    .reset_done_evt(ev[0]), .ctrl_protect_evt(ev[1]), .cs_early_loss_evt(ev[2]),
    .header_parity_evt(ev[3]), .tx_check_seq_evt(ev[4]), .tx_stamp_evt(ev[7:5]),
    .port1_phy_irq_in(phy_in), .phy_irq_unmask(phy_unmask), .rx_overflow_evt(ev[8]),
    .cut_through_en(cut_en), .tx_underrun_evt(ev[9]), .tx_abort(tx_abort),
    .tx_overflow_evt(ev[10]), .tx_wr(ev[11]), .tx_sof(ev[12]), .tx_wr_accept(tx_wr_accept),
    .tx_discard(tx_discard), .chunk_mode(chunk_mode), .chunk_dv(ev[13]), .chunk_sv(ev[14]),
    .chunk_ev(ev[15]), .tx_frame_size_reg_wr(ev[16]), .tx_frame_incomplete(incomplete),
    .tx_fifo_used(fifo_used));
  hps_status_host i_hps_status_host (.clk(clk), .resetn(resetn), .link(link.host),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd),
    .usr_rdata(usr_rdata), .tx_need_chunks(need), .tx_may_write(tx_may_write));
  hps_monitor i_hps_monitor (.clk(clk), .resetn(resetn), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .int_n(link.int_n),
    .footer_ext_status_bit(link.footer_ext_status_bit),
    .footer_tx_credit(link.footer_tx_credit));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic usr_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    usr_addr <= a;
    usr_wdata <= d;
    usr_wr <= 1'b1;
    @(posedge clk);
    usr_wr <= 1'b0;
  endtask : usr_write

  // Read data stand only in the cycle after the strobe
  task automatic usr_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    usr_addr <= a;
    usr_rd <= 1'b1;
    @(posedge clk);
    usr_rd <= 1'b0;
    #1 check(usr_rdata, exp);
  endtask : usr_read

  // One-cycle pulse on the event inputs; samples comb and registered answers
  task automatic pulse(input logic [16:0] e);
    @(posedge clk);
    ev <= e;
    #1 last_acc = tx_wr_accept;
    @(posedge clk);
    ev <= '0;
    #1 last_abort = tx_abort;
  endtask : pulse

  // Poll once with auto-clear off, then read the host's copy of the status
  task automatic status_chk(input logic [31:0] exp);
    usr_write(8'h00, 32'h2);
    repeat (8) @(posedge clk);
    usr_read(8'h04, exp);
  endtask : status_chk

  task automatic run(input logic [16:0] e, input logic [31:0] exp);
    pulse(e);
    status_chk(exp);
    usr_write(8'h08, 32'h1FFF);
    repeat (6) @(posedge clk);
    status_chk(32'h0);
  endtask : run

  // Hang guard, far beyond the roughly 800 cycles the tests need
  initial begin
    #300us;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    resetn = 1'b0;
    ev = '0;
    // FIFO never starved in cut-through except forced underruns
    {chunk_mode, cut_en, incomplete, phy_in, phy_unmask} = 5'h18;
    fifo_used = 16'h0;
    need = 5'h1;
    {usr_addr, usr_wdata, usr_wr, usr_rd} = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 check({31'h0, link.footer_ext_status_bit}, 32'h1);
    check({31'h0, link.int_n}, 32'h0);
    repeat (12) @(posedge clk);
    usr_read(8'h04, 32'h000000C0);
    usr_read(8'h0C, 32'h0000001F);
    usr_read(8'h00, 32'h00000001);
    $display("reset test done");
    usr_write(8'h00, 32'h0);
    run(17'h00001, 32'h40);
    run(17'h00002, 32'h1010);
    run(17'h00004, 32'h10);
    run(17'h00008, 32'h20);
    run(17'h00010, 32'h800);
    run(17'h00080, 32'h400);
    run(17'h00040, 32'h200);
    run(17'h00020, 32'h100);
    run(17'h00100, 32'h8);
    run(17'h00200, 32'h4);
    check({31'h0, last_abort}, 32'h1);
    run(17'h00400, 32'h2);
    check({31'h0, tx_discard}, 32'h1);
    pulse(17'h00800);
    check({31'h0, last_acc}, 32'h0);
    pulse(17'h01000);
    pulse(17'h00800);
    check({31'h0, last_acc}, 32'h1);
    $display("flag test done");
    // A zero write keeps the flag, and a set in the clear cycle wins
    pulse(17'h00008);
    usr_write(8'h08, 32'h0);
    repeat (6) @(posedge clk);
    status_chk(32'h20);
    usr_write(8'h08, 32'h20);
    // The host puts the clear on the link one cycle later; raise the set beside it
    @(posedge clk);
    ev <= 17'h00008;
    #1 check({31'h0, link.wr}, 32'h1);
    @(posedge clk);
    ev <= '0;
    repeat (6) @(posedge clk);
    status_chk(32'h20);
    run(17'h00000, 32'h20);
    $display("clear test done");
    run(17'h02000, 32'h1);
    pulse(17'h06000);
    run(17'h06000, 32'h1);
    pulse(17'h0A000);
    chunk_mode <= 1'b0;
    incomplete <= 1'b1;
    run(17'h10000, 32'h1);
    incomplete <= 1'b0;
    run(17'h10000, 32'h0);
    run(17'h00008, 32'h0);
    cut_en <= 1'b0;
    run(17'h00200, 32'h0);
    check({31'h0, last_abort}, 32'h0);
    $display("framing test done");
    phy_in <= 1'b1;
    repeat (6) @(posedge clk);
    status_chk(32'h80);
    check({31'h0, link.int_n}, 32'h1);
    usr_write(8'h08, 32'h80);
    repeat (6) @(posedge clk);
    status_chk(32'h80);
    phy_unmask <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check({31'h0, link.int_n}, 32'h0);
    phy_in <= 1'b0;
    phy_unmask <= 1'b0;
    repeat (6) @(posedge clk);
    status_chk(32'h0);
    $display("phy test done");
    // 4000 bytes used leaves one whole 64-byte chunk free
    fifo_used <= 16'h0FA0;
    repeat (4) @(posedge clk);
    usr_read(8'h0C, 32'h1);
    check({31'h0, tx_may_write}, 32'h1);
    need <= 5'h2;
    @(posedge clk);
    #1 check({31'h0, tx_may_write}, 32'h0);
    $display("credit test done");
    wrap_up();
  end
endmodule : test_host_port_status_flags
